/* File: logic/external_memory_bus_controller.v */
// Purpose: Bus sequencing unit for four external SRAM/ROM regions
// Assumes: Single 20 MHz clock, synchronous inputs, CPU holds request until ready
// Notes: Registers reached over Avalon-MM word addresses
`include "bus_controller_defs.vh"

module external_memory_bus_controller (
	input wire clock,
	input wire reset,
	// Avalon-MM register slave
	input wire [31:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output wire waitrequest,
	// CPU access port
	input wire memRequest,
	input wire [31:0] memAddress,
	input wire memWrite,
	input wire [1:0] memByteEnable,
	input wire [15:0] memWriteData,
	output wire memReady,
	output wire [15:0] memReadData,
	output wire ramSelect,
	// External bus pins
	output wire [21:1] extAddress,
	output wire [15:0] dataOut,
	output wire dataOutEnable,
	input wire [15:0] dataIn,
	output wire [3:0] regionSelectN,
	output wire readStrobeN,
	output wire upperByteWriteStrobeN,
	output wire lowerByteWriteStrobeN,
	input wire waitN
);
	// ****************************************************************
	// States
	// ****************************************************************
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_GAP = 5'h02;
	localparam [4:0] S_LEAD = 5'h04;
	localparam [4:0] S_ACCESS = 5'h08;
	localparam [4:0] S_TRAIL = 5'h10;

	// ****************************************************************
	// Register slave
	// ****************************************************************
	wire [15:0] idleExtControl;
	wire [15:0] waitControl;
	reg respond_q;
	wire busRequest = read | write;
	wire hitIdleExt = (address == `REG_IDLE_EXT_OFFSET);
	wire hitWait = (address == `REG_WAIT_OFFSET);
	// One wait cycle so that read data can come from a flop
	assign waitrequest = busRequest & ~respond_q;

	always @(posedge clock) begin
		if (reset) begin
			respond_q <= 1'b0;
			readdata <= 32'h00000000;
		end else begin
			respond_q <= busRequest & ~respond_q;
			if (read & ~respond_q) begin
				if (hitIdleExt) begin
					readdata <= {16'h0000, idleExtControl};
				end else if (hitWait) begin
					readdata <= {16'h0000, waitControl};
				end else begin
					readdata <= 32'h00000000;
				end
			end
		end
	end

	byte_lane_register #(
		.WRITE_MASK(`IDLE_EXT_WRITE_MASK),
		.RESET_VALUE(`REG_RESET_VALUE)
	) idleExtReg (
		.clock(clock),
		.reset(reset),
		.writeEnable(write & respond_q & hitIdleExt),
		.byteEnable(byteenable[1:0]),
		.writeData(writedata[15:0]),
		.value(idleExtControl)
	);

	// Only the two-bit wait fields are writable; the rest read as ones
	byte_lane_register #(
		.WRITE_MASK(`WAIT_WRITE_MASK),
		.RESET_VALUE(`REG_RESET_VALUE)
	) waitReg (
		.clock(clock),
		.reset(reset),
		.writeEnable(write & respond_q & hitWait),
		.byteEnable(byteenable[1:0]),
		.writeData(writedata[15:0]),
		.value(waitControl)
	);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire isExternal = (memAddress[31:24] == `SPACE_EXTERNAL) &&
		(memAddress[23:0] >= `REGION0_START);
	wire isRam = (memAddress >= `RAM_START);
	wire [1:0] reqRegion = memAddress[23:22];

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	reg [4:0] state_q;
	reg [4:0] state_d;
	reg [1:0] region_q;
	reg writeCycle_q;
	reg [1:0] byteEn_q;
	reg [21:1] addr_q;
	reg [15:0] wdata_q;
	reg [15:0] rdata_q;
	reg [1:0] count_q;
	reg [1:0] idleSeen_q;
	reg prevValid_q;
	reg prevRead_q;
	reg [1:0] prevRegion_q;
	reg done_q;

	// ****************************************************************
	// Per-region fields
	// ****************************************************************
	// Fixed slices per region keep variable part-selects out of the control words
	reg [1:0] prevIdleCount;
	reg prevSameIdle;
	reg reqExtend;
	reg curExtend;
	reg [1:0] reqWaits;
	reg [1:0] curWaits;

	always @* begin
		prevIdleCount = `IDLE_SATURATE;
		prevSameIdle = 1'b1;
		case (prevRegion_q)
			2'h0: begin
				prevIdleCount = idleExtControl[`IDLE_COUNT_BASE +: 2];
				prevSameIdle = idleExtControl[`SAME_IDLE_BASE];
			end
			2'h1: begin
				prevIdleCount = idleExtControl[`IDLE_COUNT_BASE + 2 +: 2];
				prevSameIdle = idleExtControl[`SAME_IDLE_BASE + 1];
			end
			2'h2: begin
				prevIdleCount = idleExtControl[`IDLE_COUNT_BASE + 4 +: 2];
				prevSameIdle = idleExtControl[`SAME_IDLE_BASE + 2];
			end
			2'h3: begin
				prevIdleCount = idleExtControl[`IDLE_COUNT_BASE + 6 +: 2];
				prevSameIdle = idleExtControl[`SAME_IDLE_BASE + 3];
			end
			default: begin
				prevIdleCount = `IDLE_SATURATE;
				prevSameIdle = 1'b1;
			end
		endcase
	end

	always @* begin
		reqExtend = 1'b1;
		reqWaits = 2'h3;
		case (reqRegion)
			2'h0: begin
				reqExtend = idleExtControl[`SELECT_EXT_BASE];
				reqWaits = waitControl[`WAIT_FIELD_BASE +: 2];
			end
			2'h1: begin
				reqExtend = idleExtControl[`SELECT_EXT_BASE + 1];
				reqWaits = waitControl[`WAIT_FIELD_BASE + `WAIT_FIELD_STRIDE +: 2];
			end
			2'h2: begin
				reqExtend = idleExtControl[`SELECT_EXT_BASE + 2];
				reqWaits = waitControl[`WAIT_FIELD_BASE + `WAIT_FIELD_STRIDE * 2 +: 2];
			end
			2'h3: begin
				reqExtend = idleExtControl[`SELECT_EXT_BASE + 3];
				reqWaits = waitControl[`WAIT_FIELD_BASE + `WAIT_FIELD_STRIDE * 3 +: 2];
			end
			default: begin
				reqExtend = 1'b1;
				reqWaits = 2'h3;
			end
		endcase
	end

	always @* begin
		curExtend = 1'b1;
		curWaits = 2'h3;
		case (region_q)
			2'h0: begin
				curExtend = idleExtControl[`SELECT_EXT_BASE];
				curWaits = waitControl[`WAIT_FIELD_BASE +: 2];
			end
			2'h1: begin
				curExtend = idleExtControl[`SELECT_EXT_BASE + 1];
				curWaits = waitControl[`WAIT_FIELD_BASE + `WAIT_FIELD_STRIDE +: 2];
			end
			2'h2: begin
				curExtend = idleExtControl[`SELECT_EXT_BASE + 2];
				curWaits = waitControl[`WAIT_FIELD_BASE + `WAIT_FIELD_STRIDE * 2 +: 2];
			end
			2'h3: begin
				curExtend = idleExtControl[`SELECT_EXT_BASE + 3];
				curWaits = waitControl[`WAIT_FIELD_BASE + `WAIT_FIELD_STRIDE * 3 +: 2];
			end
			default: begin
				curExtend = 1'b1;
				curWaits = 2'h3;
			end
		endcase
	end

	// Idle demanded by the previous access, before counting bus-free cycles
	wire sameRegion = (reqRegion == prevRegion_q);
	wire [1:0] iwNeed = (prevRead_q && (!sameRegion || memWrite)) ? prevIdleCount : 2'h0;
	wire [1:0] cwNeed = (sameRegion && prevSameIdle) ? 2'h1 : 2'h0;
	wire [1:0] gapNeed = prevValid_q ? ((iwNeed > cwNeed) ? iwNeed : cwNeed) : 2'h0;
	wire [1:0] gapLeft = (gapNeed > idleSeen_q) ? gapNeed - idleSeen_q : 2'h0;
	// The answered request still stands while ready pulses; it must not start a second access
	wire extStart = (state_q == S_IDLE) && memRequest && isExternal && !done_q;
	wire accessEnd = (state_q == S_ACCESS) && (count_q == 2'h0) && waitN;

	always @* begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (extStart) begin
					if (gapLeft != 2'h0) begin
						state_d = S_GAP;
					end else if (reqExtend) begin
						state_d = S_LEAD;
					end else begin
						state_d = S_ACCESS;
					end
				end
			end
			S_GAP: begin
				if (count_q == 2'h1) begin
					state_d = curExtend ? S_LEAD : S_ACCESS;
				end
			end
			S_LEAD: begin
				state_d = S_ACCESS;
			end
			S_ACCESS: begin
				if (accessEnd) begin
					state_d = curExtend ? S_TRAIL : S_IDLE;
				end
			end
			S_TRAIL: begin
				state_d = S_IDLE;
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	always @(posedge clock) begin
		if (reset) begin
			state_q <= S_IDLE;
			region_q <= 2'h0;
			writeCycle_q <= 1'b0;
			byteEn_q <= 2'h0;
			addr_q <= 21'h000000;
			wdata_q <= 16'h0000;
			rdata_q <= 16'h0000;
			count_q <= 2'h0;
			idleSeen_q <= `IDLE_SATURATE;
			prevValid_q <= 1'b0;
			prevRead_q <= 1'b0;
			prevRegion_q <= 2'h0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q <= accessEnd;
			if (extStart) begin
				region_q <= reqRegion;
				writeCycle_q <= memWrite;
				byteEn_q <= memByteEnable;
				addr_q <= memAddress[21:1];
				wdata_q <= memWriteData;
				count_q <= (gapLeft != 2'h0) ? gapLeft : reqWaits;
			end else if (state_q == S_GAP) begin
				count_q <= (count_q == 2'h1) ? curWaits : count_q - 2'h1;
			end else if ((state_q == S_ACCESS) && (count_q != 2'h0)) begin
				count_q <= count_q - 2'h1;
			end
			// Bus-free cycles already count toward the idle gap
			if (extStart) begin
				idleSeen_q <= 2'h0;
			end else if ((state_q == S_IDLE || state_q == S_GAP) && idleSeen_q != `IDLE_SATURATE) begin
				idleSeen_q <= idleSeen_q + 2'h1;
			end
			if (accessEnd) begin
				prevValid_q <= 1'b1;
				prevRead_q <= ~writeCycle_q;
				prevRegion_q <= region_q;
				if (!writeCycle_q) begin
					rdata_q <= dataIn;
				end
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	wire selectPhase = (state_q == S_LEAD) || (state_q == S_ACCESS) || (state_q == S_TRAIL);
	wire strobePhase = (state_q == S_ACCESS);
	wire idleState = (state_q == S_IDLE);
	// Reserved space is answered at once so a stray access cannot hang the CPU
	wire reservedHit = idleState && memRequest && !isExternal && !isRam;

	assign ramSelect = idleState && memRequest && isRam;
	assign memReady = done_q | ramSelect | reservedHit;
	assign memReadData = rdata_q;
	assign extAddress = addr_q;
	assign dataOut = wdata_q;
	// Write data held through the trailing cycle for extra hold time
	assign dataOutEnable = selectPhase && writeCycle_q;
	assign regionSelectN = selectPhase ? ~(4'h1 << region_q) : 4'hF;
	assign readStrobeN = ~(strobePhase && !writeCycle_q);
	assign upperByteWriteStrobeN = ~(strobePhase && writeCycle_q && byteEn_q[1]);
	assign lowerByteWriteStrobeN = ~(strobePhase && writeCycle_q && byteEn_q[0]);
endmodule // external_memory_bus_controller

/* File: include/bus_controller_defs.vh */
// Purpose: Shared constants of the external memory bus controller
// Assumes: Included by its bare name from the design files
// Notes: Register offsets double as Avalon word addresses
`ifndef BUS_CONTROLLER_DEFS_VH
`define BUS_CONTROLLER_DEFS_VH

// ****************************************************************
// Registers
// ****************************************************************
`define REG_IDLE_EXT_OFFSET 32'hFFFF8622
`define REG_WAIT_OFFSET 32'hFFFF8624
`define REG_RESET_VALUE 16'hFFFF
`define WAIT_WRITE_MASK 16'h3333
`define IDLE_EXT_WRITE_MASK 16'hFFFF

// ****************************************************************
// Field positions
// ****************************************************************
`define IDLE_COUNT_BASE 8
`define SAME_IDLE_BASE 4
`define SELECT_EXT_BASE 0
`define WAIT_FIELD_BASE 0
`define WAIT_FIELD_STRIDE 4

// ****************************************************************
// Address map
// ****************************************************************
`define SPACE_EXTERNAL 8'h00
`define REGION0_START 24'h200000
`define RAM_START 32'hFFFFE800

// ****************************************************************
// Timing
// ****************************************************************
`define IDLE_SATURATE 2'h3

`endif

/* File: logic/byte_lane_register.v */
// Purpose: 16-bit control register with two byte-lane writes
// Assumes: Synchronous active-high reset
// Notes: Bits outside the write mask keep their reset value
module byte_lane_register #(
	parameter [15:0] WRITE_MASK = 16'hFFFF,
	parameter [15:0] RESET_VALUE = 16'hFFFF
) (
	input wire clock,
	input wire reset,
	input wire writeEnable,
	input wire [1:0] byteEnable,
	input wire [15:0] writeData,
	output wire [15:0] value
);
	reg [15:0] value_q;
	wire [15:0] laneMask = {{8{byteEnable[1]}}, {8{byteEnable[0]}}} & WRITE_MASK;

	always @(posedge clock) begin
		if (reset) begin
			value_q <= RESET_VALUE;
		end else if (writeEnable) begin
			value_q <= (value_q & ~laneMask) | (writeData & laneMask);
		end
	end

	assign value = value_q;
endmodule // byte_lane_register

/* File: verification/bus_controller_chk.sv */
// Purpose: Port checker for the bus sequencing unit
// Assumes: One clock, synchronous reset
// Notes: Bound onto the design top
module bus_controller_chk (
	input wire clock,
	input wire reset,
	input wire read,
	input wire write,
	input wire waitrequest,
	input wire memRequest,
	input wire [31:0] memAddress,
	input wire memWrite,
	input wire [1:0] memByteEnable,
	input wire [15:0] memWriteData,
	input wire memReady,
	input wire ramSelect,
	input wire [21:1] extAddress,
	input wire [15:0] dataOut,
	input wire dataOutEnable,
	input wire [3:0] regionSelectN,
	input wire readStrobeN,
	input wire upperByteWriteStrobeN,
	input wire lowerByteWriteStrobeN,
	input wire waitN
);
	timeunit 1ns;
	timeprecision 1ns;
	wire idleStrobes = readStrobeN & upperByteWriteStrobeN & lowerByteWriteStrobeN;
	wire [1:0] lanes = {~upperByteWriteStrobeN, ~lowerByteWriteStrobeN};
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	oneSelect_a: assert property ($countones(~regionSelectN) <= 1)
		else $error("two selects low");
	regionDecode_a: assert property (memRequest && regionSelectN != 4'hF |->
		regionSelectN == ~(4'h1 << memAddress[23:22])) else $error("wrong select");
	addrOut_a: assert property (memRequest && !readStrobeN |-> extAddress == memAddress[21:1])
		else $error("address pins wrong");
	readOnly_a: assert property (!readStrobeN |-> lanes == 2'h0 && !dataOutEnable)
		else $error("read with write strobe");
	writeLanes_a: assert property (memRequest && lanes != 2'h0 |->
		memWrite && lanes == memByteEnable && dataOutEnable) else $error("lane strobes wrong");
	laneData_a: assert property (memRequest && !lowerByteWriteStrobeN |->
		dataOut[7:0] == memWriteData[7:0]) else $error("write data wrong");
	strobeInSelect_a: assert property (!idleStrobes |-> regionSelectN != 4'hF)
		else $error("strobe outside select");
	waitHold_a: assert property (!waitN && !idleStrobes |=> !idleStrobes)
		else $error("wait input ignored");
	ramOneState_a: assert property (memRequest && ramSelect |-> memReady && regionSelectN == 4'hF)
		else $error("ram access slow");
	regAnswer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("register answer late");
endmodule // bus_controller_chk

bind external_memory_bus_controller bus_controller_chk i_chk (.clock(clock), .reset(reset), .read(read),
	.write(write), .waitrequest(waitrequest), .memRequest(memRequest), .memAddress(memAddress),
	.memWrite(memWrite), .memByteEnable(memByteEnable), .memWriteData(memWriteData), .memReady(memReady),
	.ramSelect(ramSelect), .extAddress(extAddress), .dataOut(dataOut), .dataOutEnable(dataOutEnable),
	.regionSelectN(regionSelectN), .readStrobeN(readStrobeN), .upperByteWriteStrobeN(upperByteWriteStrobeN),
	.lowerByteWriteStrobeN(lowerByteWriteStrobeN), .waitN(waitN));

/* File: verification/ext_memory_model.sv */
// Purpose: Halfword SRAM with byte lanes and wait input
// Assumes: Four words per region
// Notes: Released data lines show the inverse of the last read
module ext_memory_model (
	input wire logic clock,
	input wire logic [3:0] regionSelectN,
	input wire logic readStrobeN,
	input wire logic upperByteWriteStrobeN,
	input wire logic lowerByteWriteStrobeN,
	input wire logic [21:1] extAddress,
	input wire logic [15:0] dataOut,
	input wire logic [1:0] extraWaits,
	output logic [15:0] dataIn,
	output logic waitN
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:15];
	logic [15:0] lastQ = 16'h0000;
	logic [1:0] held = 2'h0;
	wire logic [3:0] idx = {~regionSelectN[3] | ~regionSelectN[2], ~regionSelectN[3] | ~regionSelectN[1], extAddress[2:1]};
	wire logic active = !(readStrobeN && upperByteWriteStrobeN && lowerByteWriteStrobeN);
	assign waitN = !(active && held < extraWaits);
	assign dataIn = readStrobeN ? ~lastQ : mem[idx];
	always @(posedge clock) begin
		held <= !active ? 2'h0 : (held == 2'h3 ? held : held + 2'h1);
		if (!readStrobeN)
			lastQ <= mem[idx];
		if (!upperByteWriteStrobeN)
			mem[idx][15:8] <= dataOut[15:8];
		if (!lowerByteWriteStrobeN)
			mem[idx][7:0] <= dataOut[7:0];
	end
endmodule // ext_memory_model

/* File: verification/tb.sv */
// Purpose: Register and external access tests
// Assumes: Design timing as handed over
// Notes: Latency counts edges from request to ready
`include "bus_controller_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, reset = 1, read = 0, write = 0, memRequest = 0, memWrite = 0;
	logic [31:0] address = 0, writedata = 0, memAddress = 0;
	logic [3:0] byteenable = 0;
	logic [1:0] memByteEnable = 0, extraWaits = 0;
	logic [15:0] memWriteData = 0, q, lat;
	wire [31:0] readdata;
	wire [15:0] memReadData, dataOut, dataIn;
	wire [21:1] extAddress;
	wire [3:0] regionSelectN;
	wire waitrequest, memReady, ramSelect, dataOutEnable, readStrobeN, upperN, lowerN, waitN;
	int fail_count = 0, samples_checked = 0, r;
	always #25 clock = ~clock;
	external_memory_bus_controller i_dut (.clock(clock), .reset(reset), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .memRequest(memRequest), .memAddress(memAddress), .memWrite(memWrite),
		.memByteEnable(memByteEnable), .memWriteData(memWriteData), .memReady(memReady),
		.memReadData(memReadData), .ramSelect(ramSelect), .extAddress(extAddress), .dataOut(dataOut),
		.dataOutEnable(dataOutEnable), .dataIn(dataIn), .regionSelectN(regionSelectN), .readStrobeN(readStrobeN),
		.upperByteWriteStrobeN(upperN), .lowerByteWriteStrobeN(lowerN), .waitN(waitN));
	ext_memory_model i_mem (.clock(clock), .regionSelectN(regionSelectN), .readStrobeN(readStrobeN),
		.upperByteWriteStrobeN(upperN), .lowerByteWriteStrobeN(lowerN), .extAddress(extAddress),
		.dataOut(dataOut), .extraWaits(extraWaits), .dataIn(dataIn), .waitN(waitN));
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic reg_io(input logic wr, input logic [31:0] a, input logic [15:0] d);
		int n;
		@(posedge clock);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {16'h0000, d};
		byteenable <= 4'h3;
		for (n = 0; n < 20; n++) begin
			@(posedge clock);
			if (waitrequest === 1'b0)
				break;
		end
		if (n == 20) begin
			check("register timeout", 0, 1);
			print_verdict();
		end
		q = readdata[15:0];
		read <= 0;
		write <= 0;
	endtask
	task automatic cpu(input logic wr, input logic [31:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge clock);
		memAddress <= a;
		memWrite <= wr;
		memByteEnable <= be;
		memWriteData <= d;
		memRequest <= 1;
		for (lat = 0; lat < 40; lat++) begin
			@(posedge clock);
			if (memReady === 1'b1)
				break;
		end
		lat++;
		if (lat > 40) begin
			check("access timeout", 0, 1);
			print_verdict();
		end
		q = memReadData;
		memRequest <= 0;
	endtask
	function automatic logic [31:0] ea(input int k);
		return 32'h00200000 + 32'h00400000 * k + 2 * k;
	endfunction
	initial begin
		repeat (12) @(posedge clock);
		reset <= 0;
		reg_io(0, `REG_IDLE_EXT_OFFSET, 0);
		check("idle reg reset", `REG_RESET_VALUE, q);
		reg_io(0, `REG_WAIT_OFFSET, 0);
		check("wait reg reset", `REG_RESET_VALUE, q);
		reg_io(0, 32'hFFFF8626, 0);
		check("unmapped read", 0, q);
		reg_io(1, `REG_WAIT_OFFSET, 0);
		reg_io(0, `REG_WAIT_OFFSET, 0);
		check("wait reg fixed bits", ~`WAIT_WRITE_MASK, q);
		reg_io(1, `REG_IDLE_EXT_OFFSET, 0);
		for (r = 0; r < 4; r++) begin
			cpu(1, ea(r), 2'b11, 16'hA500 + r[15:0]);
			cpu(1, ea(r), 2'b10, 16'h3CFF);
			cpu(0, ea(r), 2'b00, 0);
			check("byte lanes", 16'h3C00 + r[15:0], q);
			check("plain latency", 3, lat);
			reg_io(1, `REG_WAIT_OFFSET, {6'h00, r[1:0], 8'h00});
			cpu(0, ea(2), 2'b00, 0);
			check("wait latency", 3 + r[15:0], lat);
			reg_io(1, `REG_WAIT_OFFSET, 0);
		end
		reg_io(1, `REG_WAIT_OFFSET, 0);
		extraWaits <= 2;
		cpu(0, ea(3), 2'b00, 0);
		check("wait pin latency", 5, lat);
		check("wait pin data", 16'h3C03, q);
		extraWaits <= 0;
		cpu(0, `RAM_START, 2'b00, 0);
		check("ram latency", 1, lat);
		reg_io(1, `REG_IDLE_EXT_OFFSET, 16'h0300);
		cpu(0, ea(0), 2'b00, 0);
		cpu(0, ea(1), 2'b00, 0);
		check("idle after read", 4, lat);
		reg_io(1, `REG_IDLE_EXT_OFFSET, 16'h0001);
		cpu(0, ea(0), 2'b00, 0);
		check("extension latency", 4, lat);
		print_verdict();
	end
endmodule // tb
